// ===== tmsp_pkg.sv
// Package for the test-mode serial port: frame layout, unlock values, timing constants
package tmsp_pkg;
    localparam int FRAME_BITS = 16;
    localparam int ADDR_BITS = 6;
    localparam int DATA_BITS = 8;
    localparam int ADDR_MSB = 15;
    localparam int ADDR_LSB = 10;
    localparam int DIR_POS = 9;
    localparam logic [4:0] READ_FIRST_FALL = 5'h08;
    localparam logic [4:0] READ_LAST_FALL = 5'h0f;
    localparam logic [4:0] WRITE_FIRST_RISE = 5'h09;
    localparam logic [4:0] WRITE_LAST_RISE = 5'h10;
    localparam logic [5:0] UNLOCK_ADDR = 6'h30;
    localparam logic [5:0] PROG_CTRL_ADDR = 6'h20;
    localparam logic [5:0] PROG_STAT_ADDR = 6'h29;
    localparam logic [7:0] UNLOCK_KEY0 = 8'haa;
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] ADC_TEST_KEY = 8'h1d;
    localparam logic [7:0] OTP_TEST_KEY = 8'hc6;
    localparam logic [7:0] PROG_START_VALUE = 8'h05;
    localparam int PROG_DONE_BIT = 5;
    localparam int PROG_FAIL_BIT = 4;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int SYS_CLK_HZ = 20000000;
    localparam int OSC_FREQUENCY_KHZ = 4000;
    // Oscillator tick every SYS_CLK_HZ / osc_frequency system cycles
    localparam int OSC_DIV = SYS_CLK_HZ / (OSC_FREQUENCY_KHZ * 1000);
    localparam int PROGRAM_TIME_MS = 2;
    // Longest time: round down in oscillator ticks
    localparam int PROGRAM_TIME_TICKS = (PROGRAM_TIME_MS * OSC_FREQUENCY_KHZ) - 1;
    localparam logic [2:0] OSC_DIV_RESET = 3'h0;

    typedef enum logic [1:0] {
        TMSP_LOCKED = 2'b00,
        TMSP_KEY0 = 2'b01,
        TMSP_KEY1 = 2'b11,
        TMSP_OPEN = 2'b10
    } tmsp_unlock_t;
endpackage

// ===== tmsp_frame_if.sv
// Frame hand-off between the serial shifter and the register logic
`timescale 1ns/10ps
interface tmsp_frame_if;
    logic wr_stb;
    logic rd_stb;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport shifter (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
    modport regs (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface

// ===== tmsp_shifter.sv
// Serial shifter: samples the link clock, builds 16-bit frames, drives serial out
`timescale 1ns/10ps
module tmsp_shifter
    import tmsp_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic port_en,
    input wire logic sck,
    input wire logic sdi,
    output logic sdo,
    tmsp_frame_if.shifter fr
);
    logic [2:0] sck_sync;
    logic [1:0] sdi_sync;
    logic [4:0] edges;
    logic [15:0] shreg;
    logic [7:0] out_byte;
    logic dir_write;

    wire sck_rise = sck_sync[1] & ~sck_sync[2];
    wire sck_fall = ~sck_sync[1] & sck_sync[2];
    wire [15:0] next_shreg = {shreg[14:0], sdi_sync[1]};
    wire [4:0] next_edges = edges + 5'h01;
    wire frame_done = sck_rise && (next_edges == WRITE_LAST_RISE);
    wire addr_ready = sck_rise && (next_edges == 5'h07);
    wire in_read_window = (edges >= READ_FIRST_FALL) && (edges <= READ_LAST_FALL);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sck_sync <= 3'h0;
            sdi_sync <= 2'h0;
        end else begin
            sck_sync <= {sck_sync[1:0], sck};
            sdi_sync <= {sdi_sync[0], sdi};
        end
    end

    // Bit counter cleared by reset, by the test pin dropping or at frame end; no chip select
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            edges <= 5'h00;
            shreg <= 16'h0000;
        end else if (!port_en) begin
            edges <= 5'h00;
            shreg <= 16'h0000;
        end else if (sck_rise) begin
            // Input captured on rising edges, mode zero
            shreg <= next_shreg;
            edges <= frame_done ? 5'h00 : next_edges;
        end
    end

    // Address and direction known after the seventh rising edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fr.addr <= 6'h00;
            dir_write <= 1'b0;
        end else if (port_en && addr_ready) begin
            // Direction bit is the newest bit, the address sits just above it
            fr.addr <= next_shreg[6:1];
            dir_write <= next_shreg[0];
        end
    end

    // Data bits 9..16 land in the low byte at frame end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fr.wr_stb <= 1'b0;
            fr.rd_stb <= 1'b0;
            fr.wdata <= REG_RESET;
        end else begin
            fr.wr_stb <= port_en && frame_done && dir_write;
            fr.rd_stb <= port_en && frame_done && !dir_write;
            if (port_en && frame_done) begin
                fr.wdata <= next_shreg[7:0];
            end
        end
    end

    // Data out on falling edges 8..15, MSB first; other falls and a low port enable drive zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sdo <= 1'b0;
            out_byte <= REG_RESET;
        end else if (!port_en) begin
            sdo <= 1'b0;
        end else if (sck_fall) begin
            if (edges == READ_FIRST_FALL) begin
                sdo <= fr.rdata[7];
                out_byte <= {fr.rdata[6:0], 1'b0};
            end else if (in_read_window) begin
                sdo <= out_byte[7];
                out_byte <= {out_byte[6:0], 1'b0};
            end else begin
                sdo <= 1'b0;
            end
        end
    end
endmodule

// ===== tmsp_top.sv
// Test-mode serial port top: test gating, unlock detector, register file, OTP timer
//
// What this block does
// - Port live only while test level high.
// - Test mode only after ordered unlock writes.
// - Serial input sampled on rising clock.
// - Serial output changes on falling clock.
// - SPI mode zero, clock idles low.
// - ADC test reroutes filter pin, buffers off.
// - ADC test ends at power or pin low.
// - OTP programming finishes within two milliseconds.
// - Timing derives from the 4 MHz oscillator.
// - Frame: 6 address, direction, 8 data.
// - Direction one writes, zero reads.
// - Read byte out on falls 8-15.
// - Write byte in on rises 9-16.
`timescale 1ns/10ps
module tmsp_top
    import tmsp_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // Test pin comparator output, high above the test threshold
    input wire logic TEST_ABOVE_THRESHOLD,
    // Serial link
    input wire logic SCK,
    input wire logic SDI,
    output logic SDO,
    // Analog switch controls
    output logic ADC_TEST_MODE,
    output logic FILTER_BUF_EN,
    output logic ADC_BUF_EN,
    output logic FILTER_TO_ADC,
    // OTP programming
    output logic OTP_TEST_MODE,
    output logic OTP_PROG_ACTIVE,
    output logic OSC_TICK
);
    import tmsp_pkg::*;

    tmsp_frame_if fr();

    logic [1:0] test_sync;
    logic [2:0] osc_div;
    logic osc_tick;
    tmsp_unlock_t unlock;
    logic adc_test;
    logic otp_test;
    logic mirror_wr_en;
    logic prog_busy;
    logic prog_done;
    logic prog_fail;
    logic [12:0] prog_cnt;
    logic [7:0] regs [0:63];

    // Write strobe aimed at one address of the frame
    function automatic logic addr_hit(input logic stb, input logic [5:0] a,
        input logic [5:0] target);
        return stb && (a == target);
    endfunction

    wire port_en = test_sync[1];
    wire unlock_wr = addr_hit(fr.wr_stb, fr.addr, UNLOCK_ADDR);
    wire ctrl_wr = addr_hit(fr.wr_stb, fr.addr, PROG_CTRL_ADDR);
    // A zero written to the control slot in OTP test mode opens the mirror bytes
    wire mirror_en_wr = ctrl_wr && (fr.wdata == REG_RESET) && otp_test;
    wire osc_wrap = (osc_div == 3'(OSC_DIV - 1));
    wire prog_start = ctrl_wr && (fr.wdata == PROG_START_VALUE) && otp_test && !prog_busy;
    wire prog_timeout = prog_busy && osc_tick && (prog_cnt == 13'(PROGRAM_TIME_TICKS));
    wire [7:0] stat_byte = {2'h0, prog_done | mirror_wr_en, prog_fail, 4'h0};
    wire [7:0] next_unlock_key = (unlock == TMSP_LOCKED) ? UNLOCK_KEY0 : UNLOCK_KEY1;
    wire key_match = (unlock != TMSP_KEY1) && (fr.wdata == next_unlock_key);
    wire key_final = (unlock == TMSP_KEY1) &&
                     ((fr.wdata == ADC_TEST_KEY) || (fr.wdata == OTP_TEST_KEY));

    // Status overlays its slot; the array has no reset, unwritten bytes read unknown
    assign fr.rdata = (fr.addr == PROG_STAT_ADDR) ? stat_byte : regs[fr.addr];

    tmsp_shifter u_shifter (
        .clk(CLK_SYS),
        .resetn(RESETN),
        .port_en(port_en),
        .sck(SCK),
        .sdi(SDI),
        .sdo(SDO),
        .fr(fr)
    );

    // Test pin level synchronised; port only live above threshold
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            test_sync <= 2'h0;
        end else begin
            test_sync <= {test_sync[0], TEST_ABOVE_THRESHOLD};
        end
    end

    // Oscillator-rate tick from the system clock
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            osc_div <= OSC_DIV_RESET;
            osc_tick <= 1'b0;
        end else begin
            osc_tick <= osc_wrap;
            osc_div <= osc_wrap ? OSC_DIV_RESET : osc_div + 3'h1;
        end
    end

    // Unlock detector; a wrong value drops back to the start
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            unlock <= TMSP_LOCKED;
            adc_test <= 1'b0;
            otp_test <= 1'b0;
        end else if (!port_en) begin
            // Leaving the test level is the only exit besides power
            unlock <= TMSP_LOCKED;
            adc_test <= 1'b0;
            otp_test <= 1'b0;
        end else if (unlock_wr) begin
            case (unlock)
                TMSP_LOCKED: begin
                    unlock <= key_match ? TMSP_KEY0 : TMSP_LOCKED;
                end
                TMSP_KEY0: begin
                    unlock <= key_match ? TMSP_KEY1 : TMSP_LOCKED;
                end
                TMSP_KEY1: begin
                    unlock <= key_final ? TMSP_OPEN : TMSP_LOCKED;
                    // Sequence AA, 55, 1D selects ADC test
                    if (fr.wdata == ADC_TEST_KEY) begin
                        adc_test <= 1'b1;
                    end
                    if (fr.wdata == OTP_TEST_KEY) begin
                        otp_test <= 1'b1;
                    end
                end
                TMSP_OPEN: begin
                    // Later writes to the unlock slot leave the mode as it is
                    unlock <= TMSP_OPEN;
                end
                default: begin
                    unlock <= TMSP_LOCKED;
                end
            endcase
        end
    end

    // Register array; writes land at the addressed byte
    // Bytes from the control slot up need the mirror enable first
    always_ff @(posedge CLK_SYS) begin
        if (fr.wr_stb && (mirror_wr_en || fr.addr < PROG_CTRL_ADDR)) begin
            regs[fr.addr] <= fr.wdata;
        end
    end

    // Mirror write enable, held until the test level drops
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            mirror_wr_en <= 1'b0;
        end else if (!port_en) begin
            mirror_wr_en <= 1'b0;
        end else if (mirror_en_wr) begin
            mirror_wr_en <= 1'b1;
        end
    end

    // OTP programming timer, forced done within the bound
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            prog_busy <= 1'b0;
            prog_done <= 1'b0;
            prog_fail <= 1'b0;
            prog_cnt <= 13'h0000;
        end else if (!port_en) begin
            prog_busy <= 1'b0;
            prog_cnt <= 13'h0000;
        end else begin
            if (prog_start) begin
                // Start needs an idle timer and timeout a busy one, so they never meet
                prog_busy <= 1'b1;
                prog_done <= 1'b0;
                prog_fail <= 1'b0;
                prog_cnt <= 13'h0000;
            end else if (prog_timeout) begin
                prog_busy <= 1'b0;
                prog_done <= 1'b1;
            end else if (prog_busy && osc_tick) begin
                prog_cnt <= prog_cnt + 13'h0001;
            end
        end
    end

    // Analog routing follows ADC test mode
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            ADC_TEST_MODE <= 1'b0;
            FILTER_BUF_EN <= 1'b1;
            ADC_BUF_EN <= 1'b1;
            FILTER_TO_ADC <= 1'b0;
        end else begin
            ADC_TEST_MODE <= adc_test;
            FILTER_BUF_EN <= !adc_test;
            ADC_BUF_EN <= !adc_test;
            FILTER_TO_ADC <= adc_test;
        end
    end

    // Status pins leave the block straight from flip-flops
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            OTP_TEST_MODE <= 1'b0;
            OTP_PROG_ACTIVE <= 1'b0;
            OSC_TICK <= 1'b0;
        end else begin
            OTP_TEST_MODE <= otp_test;
            OTP_PROG_ACTIVE <= prog_busy;
            OSC_TICK <= osc_tick;
        end
    end
endmodule

// ===== tmsp_checker.sv
// Assertions on the pins of the test-mode serial port
`timescale 1ns/10ps
module tmsp_checker
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESETN,
    // Inputs
    input wire logic TEST_ABOVE_THRESHOLD,
    input wire logic SCK,
    input wire logic SDI,
    // Outputs
    input wire logic SDO,
    input wire logic ADC_TEST_MODE,
    input wire logic FILTER_BUF_EN,
    input wire logic ADC_BUF_EN,
    input wire logic FILTER_TO_ADC,
    input wire logic OTP_TEST_MODE,
    input wire logic OTP_PROG_ACTIVE,
    input wire logic OSC_TICK
);
    localparam int PROG_MAX = 40000;
    logic sck_d;
    logic [4:0] since_fall;
    logic [4:0] since_rise;
    logic [4:0] since_low;
    logic [15:0] prog_len;
    // Fall, rise and low counters saturate so a long idle stretch never wraps into a false match
    wire sck_fall = sck_d && !SCK;
    wire sck_rise = !sck_d && SCK;
    wire [4:0] next_since_fall = sck_fall ? 5'h00 :
        (&since_fall ? since_fall : since_fall + 5'h01);
    wire [4:0] next_since_rise = sck_rise ? 5'h00 :
        (&since_rise ? since_rise : since_rise + 5'h01);
    wire [4:0] next_since_low = !TEST_ABOVE_THRESHOLD ? 5'h00 :
        (&since_low ? since_low : since_low + 5'h01);
    wire [15:0] next_prog_len = OTP_PROG_ACTIVE ? prog_len + 16'h0001 : 16'h0000;
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            sck_d <= 1'b0;
            since_fall <= 5'h1f;
            since_rise <= 5'h1f;
            since_low <= 5'h00;
            prog_len <= 16'h0000;
        end else begin
            sck_d <= SCK;
            since_fall <= next_since_fall;
            since_rise <= next_since_rise;
            since_low <= next_since_low;
            prog_len <= next_prog_len;
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    sequence s_tick_gap;
        !OSC_TICK [*4] ##1 OSC_TICK;
    endsequence
    sequence s_port_off;
        !TEST_ABOVE_THRESHOLD [*5];
    endsequence
    AST_SDO_ON_FALL: assert property ($changed(SDO) |-> since_fall <= 5'h06)
        else $error("serial out moved without a clock fall");
    AST_PORT_OFF: assert property (s_port_off
        |-> !ADC_TEST_MODE && !OTP_TEST_MODE && !SDO)
        else $error("port active with test pin low");
    AST_BUF_ROUTE: assert property (ADC_TEST_MODE == FILTER_TO_ADC
        && ADC_TEST_MODE == !FILTER_BUF_EN && ADC_TEST_MODE == !ADC_BUF_EN)
        else $error("buffer or route out of step with adc mode");
    AST_ADC_EXIT: assert property ($fell(ADC_TEST_MODE) |-> since_low <= 5'h06)
        else $error("adc mode left with test pin high");
    AST_UNLOCK: assert property ($rose(ADC_TEST_MODE) || $rose(OTP_TEST_MODE)
        |-> since_rise <= 5'h0c)
        else $error("test mode entered away from a frame end");
    AST_OSC_PERIOD: assert property (OSC_TICK |=> s_tick_gap)
        else $error("oscillator tick period wrong");
    AST_PROG_BOUND: assert property (OTP_PROG_ACTIVE |-> prog_len < PROG_MAX)
        else $error("programming ran too long");
    AST_PROG_START: assert property ($rose(OTP_PROG_ACTIVE)
        |-> OTP_TEST_MODE && since_rise <= 5'h0c)
        else $error("programming started without a write");
endmodule
bind tmsp_top tmsp_checker u_chk (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
    .TEST_ABOVE_THRESHOLD(TEST_ABOVE_THRESHOLD), .SCK(SCK), .SDI(SDI), .SDO(SDO),
    .ADC_TEST_MODE(ADC_TEST_MODE), .FILTER_BUF_EN(FILTER_BUF_EN), .ADC_BUF_EN(ADC_BUF_EN),
    .FILTER_TO_ADC(FILTER_TO_ADC), .OTP_TEST_MODE(OTP_TEST_MODE),
    .OTP_PROG_ACTIVE(OTP_PROG_ACTIVE), .OSC_TICK(OSC_TICK));

// ===== tmsp_spi_host.sv
// Behavioural SPI host that clocks 16-bit frames into the port
`timescale 1ns/10ps
module tmsp_spi_host
(
    // Clock
    input wire logic clk,
    // Serial link
    output logic sck,
    output logic sdi,
    input wire logic sdo
);
    initial begin
        sck = 1'b0;
        sdi = 1'b0;
    end
    task automatic xfer(input logic [5:0] a, input logic rw, input logic [7:0] d,
        output logic [7:0] q);
        logic [15:0] w;
        w = {a, rw, 1'b0, d};
        q = 8'h00;
        for (int r = 1; r <= 16; r++) begin
            sdi = w[16 - r];
            repeat (4) @(negedge clk);
            if (r >= 9) begin
                q[16 - r] = sdo;
            end
            sck = 1'b1;
            repeat (4) @(negedge clk);
            sck = 1'b0;
        end
        repeat (4) @(negedge clk);
        // Released line shows the inverse so a stale bit cannot pass as data
        sdi = ~sdi;
    endtask
endmodule

// ===== tmsp_top_tb.sv
// Self-checking bench for the test-mode serial port
`timescale 1ns/10ps
module tmsp_top_tb;
    import tmsp_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic test_hi = 1'b0;
    logic sck, sdi, sdo, adc_test, filt_buf, adc_buf, filt_adc, otp_test, prog_act, osc_tick;
    logic [7:0] q;
    wire [7:0] route = {4'h0, adc_test, filt_buf, adc_buf, filt_adc};
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    tmsp_top uut (.CLK_SYS(clk_sys), .RESETN(resetn), .TEST_ABOVE_THRESHOLD(test_hi),
        .SCK(sck), .SDI(sdi), .SDO(sdo), .ADC_TEST_MODE(adc_test), .FILTER_BUF_EN(filt_buf),
        .ADC_BUF_EN(adc_buf), .FILTER_TO_ADC(filt_adc), .OTP_TEST_MODE(otp_test),
        .OTP_PROG_ACTIVE(prog_act), .OSC_TICK(osc_tick));
    tmsp_spi_host host (.clk(clk_sys), .sck(sck), .sdi(sdi), .sdo(sdo));
    task automatic close_out();
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        host.xfer(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [5:0] a);
        host.xfer(a, 1'b0, 8'hff, q);
    endtask
    task automatic unlock(input logic [7:0] k2);
        wr(UNLOCK_ADDR, UNLOCK_KEY0);
        wr(UNLOCK_ADDR, UNLOCK_KEY1);
        wr(UNLOCK_ADDR, k2);
        repeat (6) @(negedge clk_sys);
    endtask
    task automatic t_port_off();
        unlock(ADC_TEST_KEY);
        chk("adc mode, port off", 8'h00, {7'h0, adc_test});
        test_hi = 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic t_regs();
        wr(6'h05, 8'ha5);
        host.xfer(6'h05, 1'b1, 8'h3c, q);
        chk("old byte on write", 8'ha5, q);
        wr(6'h06, 8'h5a);
        rd(6'h05);
        chk("read byte", 8'h3c, q);
        rd(6'h06);
        chk("read other byte", 8'h5a, q);
        rd(6'h05);
        chk("read leaves byte", 8'h3c, q);
    endtask
    task automatic t_bad_unlock();
        unlock(8'h77);
        wr(UNLOCK_ADDR, ADC_TEST_KEY);
        repeat (6) @(negedge clk_sys);
        chk("adc mode, bad key", 8'h00, {7'h0, adc_test});
    endtask
    task automatic t_adc();
        unlock(ADC_TEST_KEY);
        chk("adc mode on", 8'h09, route);
        wr(UNLOCK_ADDR, 8'h00);
        chk("adc mode kept", 8'h01, {7'h0, adc_test});
        test_hi = 1'b0;
        repeat (8) @(negedge clk_sys);
        chk("adc mode off", 8'h06, route);
        test_hi = 1'b1;
        repeat (4) @(negedge clk_sys);
    endtask
    task automatic t_tick();
        int n;
        n = 0;
        repeat (50) begin
            @(negedge clk_sys);
            n += osc_tick;
        end
        chk("tick count", 8'h0a, 8'(n));
    endtask
    task automatic t_otp();
        int n;
        n = 0;
        resetn = 1'b0;
        repeat (3) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (4) @(negedge clk_sys);
        unlock(OTP_TEST_KEY);
        chk("otp mode", 8'h01, {7'h0, otp_test});
        wr(PROG_CTRL_ADDR, 8'h00);
        rd(PROG_STAT_ADDR);
        chk("write enable", 8'h01, {7'h0, q[PROG_DONE_BIT]});
        wr(PROG_CTRL_ADDR, PROG_START_VALUE);
        while (prog_act === 1'b1 && n < 41000) begin
            @(negedge clk_sys);
            n++;
        end
        chk("program time", 8'h01, {7'h0, n > 39000 && n <= 40000});
        rd(PROG_STAT_ADDR);
        chk("status", 8'h20, q & 8'h30);
    endtask
    initial begin
        repeat (10) @(negedge clk_sys);
        resetn = 1'b1;
        repeat (2) @(negedge clk_sys);
        t_port_off();
        t_regs();
        t_bad_unlock();
        t_adc();
        t_tick();
        t_otp();
        close_out();
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            close_out();
        end
    end
endmodule
